/* test/tb_ipa_flash_access.sv */
// tb_ipa_flash_access: self-checking bench for the flash access block
`timescale 1ns/1ps
module tb_ipa_flash_access;
  // ==========================================================
  // signals
  logic clk, rst, hsel, hwrite, boot_select_bit, serial_cmd_pending;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, boot_from_rom, serial_watch;
  logic flash_rd, flash_wr, flash_page_erase, flash_mass_erase;
  logic [15:0] fetch_start_addr, flash_addr;
  logic [7:0] flash_wdata, flash_rdata, wbyte_exp;
  logic flash_rvalid;
  int err_count = 0;
  int checks = 0;
  int rd_wait = 0;
  int wd_bad = 0;
  int pcyc [3] = '{0, 0, 0};
  typedef struct packed {
    logic [7:0] ofs;
    logic [31:0] wd;
    logic [7:0] exp;
  } ipa_row_t;
  // register writes and the readback they should give
  ipa_row_t rows [6] = '{
    '{8'h00, 32'hffff_ff12, 8'h12},
    '{8'h04, 32'h0000_00a5, 8'ha5},
    '{8'h0c, 32'h0000_003c, 8'h3c},
    '{8'h10, 32'h0000_00ff, 8'h7f},
    '{8'h14, 32'h0000_0000, 8'h00},
    '{8'h1c, 32'h0000_0077, 8'h00}
  };

  // ==========================================================
  // design, single slave so its ready is the bus ready
  ipa_flash_access uut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .boot_select_bit(boot_select_bit), .boot_from_rom(boot_from_rom),
    .fetch_start_addr(fetch_start_addr), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rd(flash_rd), .flash_wr(flash_wr),
    .flash_page_erase(flash_page_erase),
    .flash_mass_erase(flash_mass_erase), .flash_rdata(flash_rdata),
    .flash_rvalid(flash_rvalid), .serial_cmd_pending(serial_cmd_pending),
    .serial_watch(serial_watch)
  );

  // ==========================================================
  // clock and flash array stand-in
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [7:0] arr_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5c;
  endfunction

  // array answers three cycles into a read; idle data wiggles
  always @(posedge clk) begin
    if (flash_rd === 1'b1) rd_wait <= rd_wait + 1;
    else rd_wait <= 0;
    flash_rvalid <= (flash_rd === 1'b1 && rd_wait == 2);
    if (flash_rd === 1'b1 && rd_wait == 2) flash_rdata <= arr_byte(flash_addr);
    else flash_rdata <= ~flash_rdata;
  end

  // pulse width counters, also watch the data held during a write
  always @(posedge clk) begin
    if (flash_wr === 1'b1) pcyc[0] <= pcyc[0] + 1;
    if (flash_page_erase === 1'b1) pcyc[1] <= pcyc[1] + 1;
    if (flash_mass_erase === 1'b1) pcyc[2] <= pcyc[2] + 1;
    if (flash_wr === 1'b1 && flash_wdata !== wbyte_exp) wd_bad <= wd_bad + 1;
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b10;
    haddr <= {24'h000000, ofs};
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic set_addr(input logic [15:0] a);
    logic [31:0] d;
    xfer(1'b1, ipa_pkg::ADDR_HIGH_OFS, {24'h000000, a[15:8]}, d);
    xfer(1'b1, ipa_pkg::ADDR_LOW_OFS, {24'h000000, a[7:0]}, d);
  endtask

  // poll busy; addresses and data stay put meanwhile
  task automatic wait_idle;
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      xfer(1'b0, ipa_pkg::STATUS_OFS, 32'h00000000, d);
      n++;
    end while (d[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, d, 32'h0);
    end
  endtask

  task automatic rd_op(input logic [15:0] a, input logic [15:0] phys);
    logic [31:0] d;
    set_addr(a);
    // the low byte lands on the edge that ends set_addr
    @(posedge clk);
    chk({16'h0000, flash_addr}, {16'h0000, phys});
    xfer(1'b1, ipa_pkg::COMMAND_OFS, 32'h00000001, d);
    wait_idle();
    xfer(1'b0, ipa_pkg::READ_BYTE_OFS, 32'h00000000, d);
    chk(d, {24'h000000, arr_byte(phys)});
  endtask

  // program or erase, then a command while busy that must be dropped
  task automatic prog(input logic [7:0] cmd, input logic [7:0] tim,
                      input logic [15:0] a, input int idx, input int cyc);
    logic [31:0] d;
    int base [3];
    set_addr(a);
    xfer(1'b1, ipa_pkg::PULSE_TIM_OFS, {24'h000000, tim}, d);
    base = pcyc;
    xfer(1'b1, ipa_pkg::COMMAND_OFS, {24'h000000, cmd}, d);
    xfer(1'b1, ipa_pkg::COMMAND_OFS, 32'h00000008, d);
    wait_idle();
    chk({16'h0000, flash_addr}, {16'h0000, a});
    for (int i = 0; i < 3; i++) begin
      chk(32'(pcyc[i] - base[i]), (i == idx) ? 32'(cyc) : 32'h0);
    end
  endtask

  task automatic do_reset(input logic sel);
    boot_select_bit <= sel;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog, sized well above the few hundred cycles needed
  initial begin
    #60000;
    err_count++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    boot_select_bit = 1'b0;
    serial_cmd_pending = 1'b1;
    wbyte_exp = 8'h00;
    do_reset(1'b0);
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].ofs, rows[i].wd, d);
      xfer(1'b0, rows[i].ofs, 32'h00000000, d);
      chk(d, {24'h000000, rows[i].exp});
    end
    chk({16'h0000, flash_addr}, 32'h000012a5);
    $display("test register table done");
    // reset clears addresses and loads the timing default, erased option bit gives rom
    do_reset(1'b0);
    chk({31'h0, boot_from_rom}, 32'h00000001);
    chk({31'h0, serial_watch}, 32'h00000001);
    // watch drops two flops after the request goes away
    serial_cmd_pending <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, serial_watch}, 32'h00000000);
    serial_cmd_pending <= 1'b1;
    xfer(1'b0, ipa_pkg::STATUS_OFS, 32'h00000000, d);
    chk(d, 32'h00000002);
    xfer(1'b0, ipa_pkg::ADDR_HIGH_OFS, 32'h00000000, d);
    chk(d, {24'h000000, ipa_pkg::ADDR_RESET});
    xfer(1'b0, ipa_pkg::ADDR_LOW_OFS, 32'h00000000, d);
    chk(d, {24'h000000, ipa_pkg::ADDR_RESET});
    xfer(1'b0, ipa_pkg::PULSE_TIM_OFS, 32'h00000000, d);
    chk(d, {24'h000000, ipa_pkg::PULSE_TIM_RESET});
    do_reset(1'b1);
    chk({31'h0, boot_from_rom}, 32'h00000000);
    chk({16'h0000, fetch_start_addr}, 32'h00000000);
    chk({31'h0, serial_watch}, 32'h00000000);
    xfer(1'b0, ipa_pkg::STATUS_OFS, 32'h00000000, d);
    chk(d, 32'h00000000);
    $display("test reset and boot source done");
    // reads, the all ones address lands on the option byte
    rd_op(16'h0123, 16'h0123);
    rd_op(16'hffff, 16'h1fff);
    $display("test reads done");
    // pulse lasts steps units, one unit for zero steps, plus the cycle spent leaving the state
    xfer(1'b1, ipa_pkg::WRITE_BYTE_OFS, 32'h000000c3, d);
    wbyte_exp = 8'hc3;
    prog(8'h02, 8'h02, 16'h0456, 0, 2 * ipa_pkg::PULSE_UNIT_CYCLES + 1);
    chk(32'(wd_bad), 32'h0);
    prog(8'h04, 8'h00, 16'h0200, 1, ipa_pkg::PULSE_UNIT_CYCLES + 1);
    prog(8'h08, 8'h01, 16'h0000, 2, ipa_pkg::PULSE_UNIT_CYCLES + 1);
    // all of the programming ran with fetch in flash
    chk({31'h0, boot_from_rom}, 32'h00000000);
    $display("test program and erase done");
    finish_test();
  end
endmodule // tb_ipa_flash_access

/* verilog/ipa_boot_select.sv */
// ipa_boot_select: picks the fetch source each time reset is released
`timescale 1ns/1ps
module ipa_boot_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic boot_select_bit,
  output logic boot_from_rom,
  output logic [15:0] fetch_start_addr
);
  logic sel_meta_r;
  logic sel_sync_r;
  // ==================================================
  // option level synchroniser
  // ------------------------------------------------
  // the option level is not on our clock; two flops before any use
  always_ff @(posedge clk) begin
    sel_meta_r <= boot_select_bit;
    sel_sync_r <= sel_meta_r;
  end

  // ==================================================
  // sample on release
  // ------------------------------------------------
  // caught while rst is held, so the level at release decides; reset
  // must last three edges for a new level to get through the flops
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_from_rom <= ~sel_sync_r;
    end
  end
  // flash fetches start at zero, boot rom also at zero in its own space
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_start_addr <= ipa_pkg::FLASH_RESET_VECTOR;
    end
  end
endmodule // ipa_boot_select

/* verilog/ipa_flash_access.sv */
// ipa_flash_access: ahb-lite register block for in-system flash access
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ipa_flash_access (
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // boot source
  input wire logic boot_select_bit,
  output logic boot_from_rom,
  output logic [15:0] fetch_start_addr,
  // flash array port
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_rd,
  output logic flash_wr,
  output logic flash_page_erase,
  output logic flash_mass_erase,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_rvalid,
  // serial port activity seen by the boot routine
  input wire logic serial_cmd_pending,
  output logic serial_watch
);
  localparam int ROM_BYTES = ipa_pkg::BOOT_ROM_BYTES;
  logic [7:0] addr_high_r;
  logic [7:0] addr_low_r;
  logic [7:0] read_byte_r;
  logic [7:0] write_byte_r;
  logic [7:0] pulse_tim_r;
  logic [7:0] hidden_ctrl_r; // never decoded for bus reads
  ipa_pkg::ipa_state_t state_r;
  logic [15:0] op_addr;
  logic ph_valid_r;
  logic ph_write_r;
  logic [7:0] ph_ofs_r;
  logic start_pulse;
  logic pulse_done;
  logic busy;
  logic pend_meta_r;
  logic pend_sync_r;

  // ==================================================
  // boot source selection
  // ------------------------------------------------
  ipa_boot_select u_boot (
    .clk(clk),
    .rst(rst),
    .boot_select_bit(boot_select_bit),
    .boot_from_rom(boot_from_rom),
    .fetch_start_addr(fetch_start_addr)
  );

  // ==================================================
  // serial request synchroniser
  // ------------------------------------------------
  // the request line comes from the pin side; two flops keep a
  // metastable level off the watch output, at two cycles of delay
  always_ff @(posedge clk) begin
    pend_meta_r <= serial_cmd_pending;
    pend_sync_r <= pend_meta_r;
  end

  // boot routine only polls serial commands when running from rom
  assign serial_watch = boot_from_rom & pend_sync_r;

  // ==================================================
  // address phase capture
  // ------------------------------------------------
  // zero wait states; every transfer answers OKAY in the next cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_ofs_r <= 8'h00;
    end else if (hready) begin
      ph_valid_r <= hsel & htrans[1];
      ph_write_r <= hwrite;
      ph_ofs_r <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = (state_r != ipa_pkg::IPA_IDLE);

  // ==================================================
  // address registers
  // ------------------------------------------------
  // only the low byte lane is used, upper write bits are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_high_r <= ipa_pkg::ADDR_RESET;
      addr_low_r <= ipa_pkg::ADDR_RESET;
    end else if (ph_valid_r && ph_write_r) begin
      if (ph_ofs_r == ipa_pkg::ADDR_HIGH_OFS) begin
        addr_high_r <= hwdata[7:0];
      end else if (ph_ofs_r == ipa_pkg::ADDR_LOW_OFS) begin
        addr_low_r <= hwdata[7:0];
      end
    end
  end

  // high byte carries bits 15..8, low byte bits 7..0
  assign op_addr = {addr_high_r, addr_low_r};

  // ==================================================
  // write data and timing registers
  // ------------------------------------------------
  // write byte has no reset value; holding it is software's job
  always_ff @(posedge clk) begin
    if (ph_valid_r && ph_write_r &&
        ph_ofs_r == ipa_pkg::WRITE_BYTE_OFS) begin
      write_byte_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_tim_r <= ipa_pkg::PULSE_TIM_RESET;
    end else if (ph_valid_r && ph_write_r &&
                 ph_ofs_r == ipa_pkg::PULSE_TIM_OFS) begin
      pulse_tim_r <= {1'b0, hwdata[6:0]}; // bit 7 reads zero
    end
  end

  // ==================================================
  // hidden control register
  // ------------------------------------------------
  // latches the last command written while idle; not readable from the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      hidden_ctrl_r <= 8'h00;
    end else if (ph_valid_r && ph_write_r && !busy &&
                 ph_ofs_r == ipa_pkg::COMMAND_OFS) begin
      hidden_ctrl_r <= {4'h0, hwdata[3:0]};
    end
  end

  // ==================================================
  // operation sequencer
  // ------------------------------------------------
  // a command written while busy is ignored rather than queued
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ipa_pkg::IPA_IDLE;
    end else begin
      case (state_r)
        ipa_pkg::IPA_IDLE: begin
          if (ph_valid_r && ph_write_r &&
              ph_ofs_r == ipa_pkg::COMMAND_OFS) begin
            if (hwdata[ipa_pkg::CMD_READ_BIT]) begin
              state_r <= ipa_pkg::IPA_READ;
            end else if (|hwdata[3:1]) begin
              state_r <= ipa_pkg::IPA_PROG;
            end
          end
        end
        ipa_pkg::IPA_READ: begin
          if (flash_rvalid) begin
            state_r <= ipa_pkg::IPA_DONE;
          end
        end
        ipa_pkg::IPA_PROG: begin
          if (pulse_done) begin
            state_r <= ipa_pkg::IPA_DONE;
          end
        end
        ipa_pkg::IPA_DONE: begin
          state_r <= ipa_pkg::IPA_IDLE;
        end
        default: begin
          state_r <= ipa_pkg::IPA_IDLE;
        end
      endcase
    end
  end

  assign start_pulse = (state_r == ipa_pkg::IPA_IDLE) && ph_valid_r &&
    ph_write_r && ph_ofs_r == ipa_pkg::COMMAND_OFS &&
    !hwdata[ipa_pkg::CMD_READ_BIT] && (|hwdata[3:1]);

  // pulse width follows the timing register
  ipa_pulse_timer u_timer (
    .clk(clk),
    .rst(rst),
    .start(start_pulse),
    .steps(pulse_tim_r),
    .done(pulse_done)
  );

  // ==================================================
  // flash array strobes
  // ------------------------------------------------
  // all-ones address is redirected onto the option byte location
  always_comb begin
    if (op_addr == ipa_pkg::OPTION_ALIAS_ADDR) begin
      flash_addr = ipa_pkg::OPTION_REAL_ADDR;
    end else begin
      flash_addr = op_addr;
    end
  end

  assign flash_wdata = write_byte_r;
  assign flash_rd = (state_r == ipa_pkg::IPA_READ);
  assign flash_wr = (state_r == ipa_pkg::IPA_PROG) &&
    hidden_ctrl_r[ipa_pkg::CMD_WRITE_BIT];
  assign flash_page_erase = (state_r == ipa_pkg::IPA_PROG) &&
    hidden_ctrl_r[ipa_pkg::CMD_PAGE_ERASE_BIT];
  assign flash_mass_erase = (state_r == ipa_pkg::IPA_PROG) &&
    hidden_ctrl_r[ipa_pkg::CMD_MASS_ERASE_BIT];

  // ==================================================
  // read byte capture
  // ------------------------------------------------
  // no reset: contents are undefined until the first read
  always_ff @(posedge clk) begin
    if (state_r == ipa_pkg::IPA_READ && flash_rvalid) begin
      read_byte_r <= flash_rdata;
    end
  end

  // ==================================================
  // read mux
  // ------------------------------------------------
  // unmapped offsets, including the hidden control, read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ph_valid_r && !ph_write_r) begin
      if (ph_ofs_r == ipa_pkg::ADDR_HIGH_OFS) begin
        hrdata = {24'h00_0000, addr_high_r};
      end else if (ph_ofs_r == ipa_pkg::ADDR_LOW_OFS) begin
        hrdata = {24'h00_0000, addr_low_r};
      end else if (ph_ofs_r == ipa_pkg::READ_BYTE_OFS) begin
        hrdata = {24'h00_0000, read_byte_r};
      end else if (ph_ofs_r == ipa_pkg::WRITE_BYTE_OFS) begin
        hrdata = {24'h00_0000, write_byte_r};
      end else if (ph_ofs_r == ipa_pkg::PULSE_TIM_OFS) begin
        hrdata = {24'h00_0000, pulse_tim_r};
      end else if (ph_ofs_r == ipa_pkg::STATUS_OFS) begin
        hrdata = {30'h0000_0000, boot_from_rom, busy};
      end
    end
  end

  // ==================================================
  // assertions
  // ------------------------------------------------
  a_addr_reset_zero: assert property (@(posedge clk)
    rst |=> (addr_high_r == 8'h00 && addr_low_r == 8'h00))
    else $error("address registers not cleared by reset");
  a_tim_reset_val: assert property (@(posedge clk)
    rst |=> pulse_tim_r == 8'h7b)
    else $error("timing register reset value wrong");
  a_boot_rom_sel: assert property (@(posedge clk)
    (rst && !$past(boot_select_bit, 2)) |=> boot_from_rom)
    else $error("erased select bit did not pick boot rom");
  a_boot_flash_sel: assert property (@(posedge clk)
    (rst && $past(boot_select_bit, 2)) |=> (!boot_from_rom &&
      fetch_start_addr == 16'h0000))
    else $error("set select bit did not pick flash at zero");
  a_boot_hold: assert property (@(posedge clk) disable iff (rst)
    $stable(boot_from_rom))
    else $error("boot source changed outside reset");
  a_addr_map: assert property (@(posedge clk) disable iff (rst)
    (op_addr != 16'hffff) |-> flash_addr == {addr_high_r, addr_low_r})
    else $error("flash address not formed from address registers");
  a_option_alias: assert property (@(posedge clk) disable iff (rst)
    (op_addr == 16'hffff) |-> flash_addr == 16'h1fff)
    else $error("all ones address not aliased to option byte");
  a_read_capture: assert property (@(posedge clk) disable iff (rst)
    (flash_rd && flash_rvalid) |=> read_byte_r == $past(flash_rdata))
    else $error("read byte not captured");
  a_hidden_ctrl: assert property (@(posedge clk) disable iff (rst)
    (ph_valid_r && !ph_write_r && ph_ofs_r == 8'h14) |-> hrdata == 32'h0)
    else $error("hidden control register visible on bus");
  a_wdata_drive: assert property (@(posedge clk) disable iff (rst)
    flash_wr |-> flash_wdata == write_byte_r)
    else $error("write byte not driven to flash");
  a_high_lane: assert property (@(posedge clk) disable iff (rst)
    (ph_valid_r && ph_write_r && ph_ofs_r == 8'h00)
      |=> flash_addr[15:8] == $past(hwdata[7:0]) || op_addr == 16'hffff)
    else $error("high address byte misplaced");
  a_low_lane: assert property (@(posedge clk) disable iff (rst)
    (ph_valid_r && ph_write_r && ph_ofs_r == 8'h04)
      |=> addr_low_r == $past(hwdata[7:0]))
    else $error("low address byte misplaced");
  a_byte_read: assert property (@(posedge clk) disable iff (rst)
    hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_serial_watch: assert property (@(posedge clk) disable iff (rst)
    serial_watch |-> boot_from_rom)
    else $error("serial watch outside boot rom");
  a_rom_start_range: assert property (@(posedge clk) disable iff (rst)
    boot_from_rom |-> fetch_start_addr < 16'(ROM_BYTES))
    else $error("boot start address outside boot rom");
  a_busy_cmd_drop: assert property (@(posedge clk) disable iff (rst)
    (busy && ph_valid_r && ph_write_r &&
      ph_ofs_r == ipa_pkg::COMMAND_OFS) |=> $stable(hidden_ctrl_r))
    else $error("command taken while busy");
  c_read_op: cover property (@(posedge clk) disable iff (rst)
    flash_rd ##[1:20] state_r == ipa_pkg::IPA_DONE);
  c_write_op: cover property (@(posedge clk) disable iff (rst)
    flash_wr ##1 flash_wr);
  c_mass_erase: cover property (@(posedge clk) disable iff (rst)
    flash_mass_erase && op_addr == 16'h0000);
  c_option_read: cover property (@(posedge clk) disable iff (rst)
    flash_rd && op_addr == 16'hffff);
endmodule // ipa_flash_access

/* verilog/ipa_pkg.sv */
// ipa_pkg: register map, reset values and timing for flash program access
package ipa_pkg;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h00;
  localparam logic [7:0] ADDR_LOW_OFS = 8'h04;
  localparam logic [7:0] READ_BYTE_OFS = 8'h08;
  localparam logic [7:0] WRITE_BYTE_OFS = 8'h0c;
  localparam logic [7:0] PULSE_TIM_OFS = 8'h10;
  localparam logic [7:0] COMMAND_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  // command register fields
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_PAGE_ERASE_BIT = 2;
  localparam int CMD_MASS_ERASE_BIT = 3;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BOOT_ROM_BIT = 1;
  // reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] PULSE_TIM_RESET = 8'h7b; // 7.5 to 10 mhz setting
  // special addresses
  localparam logic [15:0] OPTION_ALIAS_ADDR = 16'hffff;
  localparam logic [15:0] OPTION_REAL_ADDR = 16'h1fff;
  localparam logic [15:0] MASS_ERASE_ADDR = 16'h0000;
  localparam logic [15:0] FLASH_RESET_VECTOR = 16'h0000;
  // boot rom size and timing
  localparam int BOOT_ROM_BYTES = 1024;
  localparam int CLK_MHZ = 250;
  localparam int PULSE_UNIT_NS = 100; // one timing step per unit
  localparam int PULSE_UNIT_CYCLES = (PULSE_UNIT_NS * CLK_MHZ) / 1000;
  typedef enum logic [3:0] {
    IPA_IDLE = 4'b0001,
    IPA_READ = 4'b0010,
    IPA_PROG = 4'b0100,
    IPA_DONE = 4'b1000
  } ipa_state_t;
endpackage

/* verilog/ipa_pulse_timer.sv */
// ipa_pulse_timer: counts the write or erase pulse width
`timescale 1ns/1ps
module ipa_pulse_timer #(
  parameter int UNIT_CYCLES = ipa_pkg::PULSE_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] steps,
  output logic done
);
  logic [15:0] unit_r;
  logic [7:0] step_r;
  logic run_r;
  // ==================================================
  // step counter
  // ------------------------------------------------
  // zero steps still takes one step so the pulse is never empty
  always_ff @(posedge clk) begin
    if (rst) begin
      run_r <= 1'b0;
      unit_r <= 16'h0000;
      step_r <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run_r <= 1'b1;
        unit_r <= 16'h0000;
        step_r <= steps;
      end else if (run_r) begin
        if (unit_r == 16'(UNIT_CYCLES - 1)) begin
          unit_r <= 16'h0000;
          if (step_r <= 8'h01) begin
            run_r <= 1'b0;
            done <= 1'b1;
          end else begin
            step_r <= step_r - 8'h01;
          end
        end else begin
          unit_r <= unit_r + 16'h0001;
        end
      end
    end
  end
endmodule // ipa_pulse_timer
